// *** src/plc_defines.svh ***
// Offsets, reset values and timing counts for the phone line control block
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

`define PLC_TONE_LATCH_ADDR 16'h0030
`define PLC_TONE_LATCH_RST 8'h00
`define PLC_CLK_HZ 100000000
`define PLC_SCAN_TICK_MS 10
`define PLC_SCAN_TICK_CYC ((`PLC_CLK_HZ / 1000) * `PLC_SCAN_TICK_MS)
`define PLC_WIDTH_W 24
`define PLC_DIAL_CNT_W 24

`endif

// *** src/plc_pkg.sv ***
// Types shared by the phone line control block
`default_nettype none
package plc_pkg;

    typedef enum logic [1:0] {
        PLC_DIAL_IDLE = 2'b00,
        PLC_DIAL_BREAK = 2'b01,
        PLC_DIAL_MAKE = 2'b11,
        PLC_DIAL_GAP = 2'b10
    } plc_dial_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr_n;
        logic strobe;
    } plc_bus_s;

    typedef struct packed {
        logic [3:0] rows;
        logic [3:0] cols;
    } plc_tone_pair_s;

endpackage
`default_nettype wire

// *** src/plc_phone_line_control.sv ***
// Telephone line control: hook relay, pulse dialer, scan tick, tone timer, tone latch
//
// Summary of operation
// [RL1] A scan tick pulse is raised every 10 ms for keyboard scanning.
// [RL2] Widths of low pulses on the tone timer input are measured.
// [RL3] Only dial tone is classified from measured pulse width.
// [RL4] Timer output pin is unused and held at a constant level.
// [RL5] Channel clock only for sync traffic with tape array; else idle.
// [RL6] Serial channel has separate receive and transmit lines.
// [RL7] Line interface pulls ring indicate low while ringing is present.
// [RL8] Driving hook control low closes the relay, seizing the line.
// [RL9] Pulse dialing opens and closes the relay once per pulse.
// [RL10] Tone detect is honoured only while hook control is low.
// [RL11] Write to address 0030h asserts tone latch select, capturing the byte.
// [RL12] Latched byte bits map to tone generator row and column inputs.
// [RL13] Modem clock 1 MHz comes from the 4 MHz filter oscillator.
// [RL14] Modem link runs full duplex at 300 baud, originate or answer.
// [RL15] High hook control leaves the line open, on hook.
// [RL16] Carrier detect input is low while carrier energy is present.
// [RL17] Break, make and inter-digit gap lengths are configurable counts.
`timescale 1ns/1ps
`default_nettype none
`include "plc_defines.svh"

module plc_phone_line_control #(
    parameter int SCAN_TICK_CYC = `PLC_SCAN_TICK_CYC,
    parameter int WIDTH_W = `PLC_WIDTH_W,
    parameter int DIAL_CNT_W = `PLC_DIAL_CNT_W
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Processor side
    input wire logic [15:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_wr_n_in,
    input wire logic bus_strobe_in,
    input wire logic seize_in,
    input wire logic [3:0] dial_digit_in,
    input wire logic dial_start_in,
    input wire logic [DIAL_CNT_W-1:0] break_cyc_in,
    input wire logic [DIAL_CNT_W-1:0] make_cyc_in,
    input wire logic [DIAL_CNT_W-1:0] gap_cyc_in,
    input wire logic [WIDTH_W-1:0] dial_tone_min_in,
    input wire logic [WIDTH_W-1:0] dial_tone_max_in,
    input wire logic sync_mode_in,
    input wire logic [7:0] ser_tx_bit_in,
    // Line side pins
    input wire logic tone_timer_input_n_in,
    input wire logic ring_indicate_n_in,
    input wire logic carrier_detect_n_in,
    input wire logic channel_receive_line_in,
    input wire logic modem_osc_in,
    // Outputs
    output logic hook_control_n_out,
    output logic tone_latch_select_n_out,
    output logic [7:0] tone_pair_latch_out,
    output logic scan_tick_out,
    output logic [WIDTH_W-1:0] pulse_width_out,
    output logic width_valid_out,
    output logic dial_tone_out,
    output logic ring_out,
    output logic carrier_out,
    output logic dial_busy_out,
    output logic timer_output_pin_out,
    output logic channel_serial_clock_out,
    output logic channel_transmit_line_out,
    output logic channel_rx_out,
    output logic modem_clk_out
);

    // ****************************************
    // Parameter checks
    // ****************************************
    // Refused at elaboration: the counters below cannot serve these
    if (SCAN_TICK_CYC < 2) begin : g_bad_scan
        $error("plc_phone_line_control: SCAN_TICK_CYC must be 2 or more");
    end
    if (WIDTH_W < 2) begin : g_bad_width
        $error("plc_phone_line_control: WIDTH_W must be 2 or more");
    end
    // Narrower dial counters could not hold any useful interval
    if (DIAL_CNT_W < 4) begin : g_bad_dial
        $error("plc_phone_line_control: DIAL_CNT_W must be 4 or more");
    end

    // ****************************************
    // State register
    // ****************************************
    typedef struct packed {
        logic [1:0] tone_s;
        logic [1:0] ring_s;
        logic [1:0] dcd_s;
        logic [1:0] rx_s;
        logic [1:0] osc_s;
        logic [31:0] scan_cnt;
        logic scan_tick;
        logic [WIDTH_W-1:0] width_cnt;
        logic in_pulse;
        logic [WIDTH_W-1:0] width;
        logic width_valid;
        logic dial_tone;
        plc_pkg::plc_dial_e dial_st;
        logic [3:0] pulses_left;
        logic [DIAL_CNT_W-1:0] dial_cnt;
        logic hook_n;
        logic latch_sel_n;
        plc_pkg::plc_tone_pair_s tone_pair;
        logic [1:0] mclk_div;
        logic osc_prev;
        logic modem_clk;
        logic ccko;
        logic channel_transmit_line;
        logic ring;
        logic carrier;
        logic busy;
        logic timer_output_pin;
    } plc_state_s;

    plc_state_s q, d;
    plc_pkg::plc_bus_s bus;

    // ****************************************
    // Processor bus decode
    // ****************************************
    assign bus = '{addr: bus_addr_in, wdata: bus_wdata_in, wr_n: bus_wr_n_in,
                   strobe: bus_strobe_in};

    // Only writes decode; a read of the latch address is simply ignored
    function automatic logic is_latch_write(input plc_pkg::plc_bus_s b);
        is_latch_write = b.strobe && !b.wr_n && (b.addr == `PLC_TONE_LATCH_ADDR);
    endfunction

    // Digit zero sends ten pulses
    function automatic logic [3:0] pulse_count(input logic [3:0] digit);
        pulse_count = (digit == 4'h0) ? 4'ha : digit;
    endfunction

    always_comb begin
        d = q;
        // Pins from off-chip: two-stage synchronisers
        d.tone_s = {q.tone_s[0], tone_timer_input_n_in};
        d.ring_s = {q.ring_s[0], ring_indicate_n_in};
        d.dcd_s = {q.dcd_s[0], carrier_detect_n_in};
        d.rx_s = {q.rx_s[0], channel_receive_line_in};
        d.osc_s = {q.osc_s[0], modem_osc_in};

        // ****************************************
        // Ring and carrier status
        // ****************************************
        // Pins are active low; outputs are flopped inversions of the second stage
        d.ring = !q.ring_s[1]; // [RL7]
        d.carrier = !q.dcd_s[1]; // [RL16]

        // ****************************************
        // Keyboard scan tick
        // ****************************************
        // First tick comes SCAN_TICK_CYC cycles after reset release
        d.scan_tick = 1'b0;
        if (q.scan_cnt == 32'(SCAN_TICK_CYC - 1)) begin
            d.scan_cnt = 32'h0;
            d.scan_tick = 1'b1; // [RL1]
        end else begin
            d.scan_cnt = q.scan_cnt + 32'h1;
        end

        // ****************************************
        // Tone pulse width timer
        // ****************************************
        d.width_valid = 1'b0;
        // Filter is unpowered on hook, so its output is meaningless then
        if (q.hook_n) begin
            d.in_pulse = 1'b0; // [RL10]
            d.width_cnt = '0;
            d.dial_tone = 1'b0;
        end else if (!q.tone_s[1]) begin
            d.in_pulse = 1'b1;
            // Saturates so an endless tone never reads as a short one
            if (q.width_cnt != '1) begin
                d.width_cnt = q.width_cnt + 1'b1; // [RL2]
            end
        // Pulse is reported on its trailing edge
        end else if (q.in_pulse) begin
            d.in_pulse = 1'b0;
            d.width = q.width_cnt; // [RL2]
            d.width_valid = 1'b1;
            d.width_cnt = '0;
            // Other tones are not told apart
            d.dial_tone = (q.width_cnt >= dial_tone_min_in) &&
                          (q.width_cnt <= dial_tone_max_in); // [RL3]
        end

        // ****************************************
        // Hook relay and pulse dialer
        // ****************************************
        // A start while busy is dropped; the caller waits for busy to fall
        unique case (q.dial_st)
            plc_pkg::PLC_DIAL_IDLE: begin
                // Seize level is only honoured between digits
                d.hook_n = !seize_in; // [RL8] [RL15]
                if (dial_start_in && seize_in) begin
                    d.dial_st = plc_pkg::PLC_DIAL_BREAK;
                    d.pulses_left = pulse_count(dial_digit_in);
                    d.dial_cnt = '0;
                    d.hook_n = 1'b1; // [RL9]
                end
            end
            plc_pkg::PLC_DIAL_BREAK: begin
                d.dial_cnt = q.dial_cnt + 1'b1;
                if (q.dial_cnt >= break_cyc_in) begin // [RL17]
                    d.dial_st = plc_pkg::PLC_DIAL_MAKE;
                    d.dial_cnt = '0;
                    d.hook_n = 1'b0; // [RL9]
                    d.pulses_left = q.pulses_left - 4'h1;
                end
            end
            plc_pkg::PLC_DIAL_MAKE: begin
                d.dial_cnt = q.dial_cnt + 1'b1;
                if (q.dial_cnt >= make_cyc_in) begin // [RL17]
                    d.dial_cnt = '0;
                    if (q.pulses_left == 4'h0) begin
                        d.dial_st = plc_pkg::PLC_DIAL_GAP;
                    end else begin
                        d.dial_st = plc_pkg::PLC_DIAL_BREAK;
                        d.hook_n = 1'b1; // [RL9]
                    end
                end
            end
            plc_pkg::PLC_DIAL_GAP: begin
                d.dial_cnt = q.dial_cnt + 1'b1;
                if (q.dial_cnt >= gap_cyc_in) begin // [RL17]
                    d.dial_st = plc_pkg::PLC_DIAL_IDLE;
                    d.dial_cnt = '0;
                end
            end
        endcase
        // Flopped so busy leaves the block straight from a register
        d.busy = (d.dial_st != plc_pkg::PLC_DIAL_IDLE);

        // ****************************************
        // Tone pair latch at 0030h
        // ****************************************
        d.latch_sel_n = 1'b1;
        if (is_latch_write(bus)) begin
            d.latch_sel_n = 1'b0; // [RL11]
            d.tone_pair = plc_pkg::plc_tone_pair_s'(bus.wdata); // [RL12]
        end

        // ****************************************
        // Modem clock and serial channel
        // ****************************************
        // Divide by four, counting rising oscillator edges
        d.osc_prev = q.osc_s[1];
        if (q.osc_s[1] && !q.osc_prev) begin
            d.mclk_div = q.mclk_div + 2'h1;
            if (q.mclk_div[0]) begin
                d.modem_clk = !q.modem_clk; // [RL13]
            end
        end
        // Clock only toggles in synchronous tape mode
        d.ccko = sync_mode_in ? q.scan_cnt[2] : 1'b0; // [RL5]
        d.channel_transmit_line = ser_tx_bit_in[0]; // [RL6] [RL14]
        // Timer output pin is unused; held low so nothing sees a stray edge
        d.timer_output_pin = 1'b0; // [RL4]
    end

    // ****************************************
    // Register update
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            // Relay open and select high so the line stays idle through reset
            q <= '0;
            q.tone_s <= 2'h3;
            q.ring_s <= 2'h3;
            q.dcd_s <= 2'h3;
            q.hook_n <= 1'b1;
            q.latch_sel_n <= 1'b1;
            q.tone_pair <= `PLC_TONE_LATCH_RST;
            q.channel_transmit_line <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hook_control_n_out = q.hook_n;
    assign tone_latch_select_n_out = q.latch_sel_n;
    assign tone_pair_latch_out = q.tone_pair;
    assign scan_tick_out = q.scan_tick;
    assign pulse_width_out = q.width;
    assign width_valid_out = q.width_valid;
    assign dial_tone_out = q.dial_tone;
    assign ring_out = q.ring; // [RL7]
    assign carrier_out = q.carrier; // [RL16]
    assign dial_busy_out = q.busy;
    assign timer_output_pin_out = q.timer_output_pin; // [RL4]
    assign channel_serial_clock_out = q.ccko;
    assign channel_transmit_line_out = q.channel_transmit_line;
    assign channel_rx_out = q.rx_s[1];
    assign modem_clk_out = q.modem_clk;

endmodule
`default_nettype wire

// *** dv/plc_line_model.sv ***
// Behavioural model of the line interface, filter and modem oscillator
`timescale 1ns/1ps
`default_nettype none
module plc_line_model (
    input wire logic clk_sys_in,
    input wire logic hook_control_n_in,
    input wire logic ring_on_in,
    input wire logic carrier_on_in,
    output logic tone_timer_input_n_out,
    output logic ring_indicate_n_out,
    output logic carrier_detect_n_out,
    output logic channel_receive_line_out,
    output logic modem_osc_out
);
    logic osc_q = 1'b0;
    logic tone_q = 1'b0;
    always @(posedge clk_sys_in) osc_q <= !osc_q;
    assign modem_osc_out = osc_q;
    assign ring_indicate_n_out = !ring_on_in;
    assign carrier_detect_n_out = !carrier_on_in;
    // Idle receive line changes every cycle so a stale value never looks valid
    assign channel_receive_line_out = osc_q;
    // Filter is unpowered on hook, so its output rests high then
    assign tone_timer_input_n_out = hook_control_n_in | !tone_q;
    task automatic tone_pulse(input int n);
        @(posedge clk_sys_in);
        tone_q <= 1'b1;
        repeat (n) @(posedge clk_sys_in);
        tone_q <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** dv/plc_line_asserts.sv ***
// Port checks for the phone line control block
`timescale 1ns/1ps
`default_nettype none
module plc_line_asserts #(
    parameter int SCAN_TICK_CYC = 20,
    parameter int WIDTH_W = 24
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_wr_n_in,
    input wire logic bus_strobe_in,
    input wire logic seize_in,
    input wire logic dial_start_in,
    input wire logic [WIDTH_W-1:0] dial_tone_min_in,
    input wire logic [WIDTH_W-1:0] dial_tone_max_in,
    input wire logic sync_mode_in,
    input wire logic hook_control_n_out,
    input wire logic tone_latch_select_n_out,
    input wire logic [7:0] tone_pair_latch_out,
    input wire logic scan_tick_out,
    input wire logic [WIDTH_W-1:0] pulse_width_out,
    input wire logic width_valid_out,
    input wire logic dial_tone_out,
    input wire logic dial_busy_out,
    input wire logic timer_output_pin_out,
    input wire logic channel_serial_clock_out
);
    logic [31:0] gap_q;
    logic seen_q;
    always_ff @(posedge clk_sys_in) begin
        gap_q <= (!rst_n_in || scan_tick_out) ? 32'h0 : gap_q + 32'h1;
        seen_q <= rst_n_in && (seen_q || scan_tick_out);
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    chk_latch_write: assert property (
        bus_strobe_in && !bus_wr_n_in && bus_addr_in == 16'h0030
        |=> !tone_latch_select_n_out && tone_pair_latch_out == $past(bus_wdata_in))
        else $error("latch write missed");
    chk_select_cause: assert property (!tone_latch_select_n_out
        |-> $past(bus_strobe_in && !bus_wr_n_in && bus_addr_in == 16'h0030))
        else $error("stray latch select");
    chk_tick_period: assert property (seen_q |-> (scan_tick_out ?
        gap_q == SCAN_TICK_CYC - 1 : gap_q < SCAN_TICK_CYC - 1)) else $error("tick spacing");
    chk_dial_start: assert property (dial_start_in && seize_in && !dial_busy_out
        |=> hook_control_n_out && dial_busy_out) else $error("dial start");
    chk_seize_line: assert property ((seize_in && !dial_busy_out)[*3]
        |-> !hook_control_n_out) else $error("line not seized");
    chk_release_line: assert property ((!seize_in && !dial_busy_out)[*3]
        |-> hook_control_n_out) else $error("line not released");
    chk_tone_gate: assert property (hook_control_n_out[*4] |-> !width_valid_out)
        else $error("width on hook");
    chk_tone_class: assert property (width_valid_out |-> dial_tone_out ==
        (pulse_width_out >= dial_tone_min_in && pulse_width_out <= dial_tone_max_in))
        else $error("tone class");
    chk_timer_pin: assert property (timer_output_pin_out == 1'b0)
        else $error("timer pin moved");
    chk_clock_hold: assert property (!sync_mode_in[*3]
        |-> $stable(channel_serial_clock_out)) else $error("channel clock ran");
    cover property (!tone_latch_select_n_out);
    cover property ($rose(dial_busy_out));
    cover property (width_valid_out && dial_tone_out);
endmodule
bind plc_phone_line_control plc_line_asserts #(
    .SCAN_TICK_CYC(SCAN_TICK_CYC),
    .WIDTH_W(WIDTH_W)
) u_line_chk (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in),
    .bus_wr_n_in(bus_wr_n_in),
    .bus_strobe_in(bus_strobe_in),
    .seize_in(seize_in),
    .dial_start_in(dial_start_in),
    .dial_tone_min_in(dial_tone_min_in),
    .dial_tone_max_in(dial_tone_max_in),
    .sync_mode_in(sync_mode_in),
    .hook_control_n_out(hook_control_n_out),
    .tone_latch_select_n_out(tone_latch_select_n_out),
    .tone_pair_latch_out(tone_pair_latch_out),
    .scan_tick_out(scan_tick_out),
    .pulse_width_out(pulse_width_out),
    .width_valid_out(width_valid_out),
    .dial_tone_out(dial_tone_out),
    .dial_busy_out(dial_busy_out),
    .timer_output_pin_out(timer_output_pin_out),
    .channel_serial_clock_out(channel_serial_clock_out)
);
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the phone line control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, wr_n = 1'b1, stb = 1'b0, seize = 1'b0, start = 1'b0;
    logic sync = 1'b0, ring_on = 1'b0, dcd_on = 1'b0;
    logic [15:0] addr = 16'h0;
    logic [7:0] wd = 8'h0, tx = 8'hff, lat;
    logic [3:0] digit = 4'h1;
    logic [23:0] wid;
    logic [23:0] brk = 24'h2;
    logic tin_n, ri_n, dcd_n, rx, osc, hook_n, sel_n, tick, vld, dtone, ring, dcd, busy, cclk, channel_transmit_line;
    logic rxo, mclk, cprev, mprev;
    int bad_count = 0, n_tests = 0, k, h, m;
    int tw[3] = '{8, 30, 2};
    int dg[2] = '{1, 0};
    int bk[2] = '{2, 1};
    plc_phone_line_control #(.SCAN_TICK_CYC(20)) dut (
        .clk_sys_in(clk), .rst_n_in(rst_n), .bus_addr_in(addr), .bus_wdata_in(wd),
        .bus_wr_n_in(wr_n), .bus_strobe_in(stb), .seize_in(seize), .dial_digit_in(digit),
        .dial_start_in(start), .break_cyc_in(brk), .make_cyc_in(24'h1), .gap_cyc_in(24'h3),
        .dial_tone_min_in(24'h4), .dial_tone_max_in(24'h10), .sync_mode_in(sync),
        .ser_tx_bit_in(tx), .tone_timer_input_n_in(tin_n), .ring_indicate_n_in(ri_n),
        .carrier_detect_n_in(dcd_n), .channel_receive_line_in(rx), .modem_osc_in(osc),
        .hook_control_n_out(hook_n), .tone_latch_select_n_out(sel_n),
        .tone_pair_latch_out(lat), .scan_tick_out(tick), .pulse_width_out(wid),
        .width_valid_out(vld), .dial_tone_out(dtone), .ring_out(ring), .carrier_out(dcd),
        .dial_busy_out(busy), .timer_output_pin_out(), .channel_serial_clock_out(cclk),
        .channel_transmit_line_out(channel_transmit_line), .channel_rx_out(rxo), .modem_clk_out(mclk));
    plc_line_model line (.clk_sys_in(clk), .hook_control_n_in(hook_n), .ring_on_in(ring_on),
        .carrier_on_in(dcd_on), .tone_timer_input_n_out(tin_n), .ring_indicate_n_out(ri_n),
        .carrier_detect_n_out(dcd_n), .channel_receive_line_out(rx), .modem_osc_out(osc));
    initial begin
        forever #5 clk = !clk;
    end
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Bounded wait for valid (sel 0) or tick (sel 1); k is left holding the edges waited
    task automatic wait_hi(input bit sel, input int lim);
        for (k = 0; (sel ? tick : vld) !== 1'b1; k++) begin
            if (k == lim) begin
                bad_count++;
                end_sim();
            end
            @(posedge clk);
            #1;
        end
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, input logic w_n);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr_n <= w_n;
        stb <= 1'b1;
        @(posedge clk);
        stb <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("hook", 24'h1, hook_n);
        chk("latch", 24'h100, {sel_n, lat});
        bus_wr(16'h0030, 8'ha5, 1'b0);
        chk("select", 24'h0, sel_n);
        chk("rows cols", 24'h0a05, {4'h0, lat[7:4], 4'h0, lat[3:0]});
        bus_wr(16'h0031, 8'hff, 1'b0);
        bus_wr(16'h0030, 8'h3c, 1'b1);
        chk("ignored", 24'h1a5, {sel_n, lat});
        @(posedge clk);
        seize <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("seized", 24'h0, hook_n);
        foreach (tw[i]) begin
            line.tone_pulse(tw[i]);
            wait_hi(1'b0, 60);
            chk("dial tone", 24'(tw[i] inside {[4:16]}), dtone);
        end
        // A second start mid-dial must be dropped, else the break count doubles
        foreach (dg[i]) begin
            @(posedge clk);
            digit <= 4'(dg[i]);
            brk <= 24'(bk[i]);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            #1;
            chk("break start", 24'h1, hook_n);
            for (h = 0, k = 0; busy === 1'b1 && k < 200; k++) begin
                h += (hook_n === 1'b1);
                @(posedge clk);
                start <= (k == 2);
                #1;
            end
            if (k == 200) begin
                bad_count++;
                end_sim();
            end
            // Each break lasts break count plus one cycle; digit zero sends ten pulses
            chk("break cycles", 24'((dg[i] == 0 ? 10 : dg[i]) * (bk[i] + 1)), 24'(h));
        end
        @(posedge clk);
        ring_on <= 1'b1;
        dcd_on <= 1'b1;
        tx <= 8'hfe;
        sync <= 1'b1;
        #1;
        cprev = cclk;
        mprev = mclk;
        for (h = 0, m = 0, k = 0; k < 16; k++) begin
            @(posedge clk);
            #1;
            h += (cclk !== cprev);
            m += (mclk !== mprev);
            cprev = cclk;
            mprev = mclk;
        end
        // Model oscillator is half the system clock; a quarter of it toggles every 4 cycles
        chk("modem clock", 24'd4, 24'(m));
        // Line toggles every cycle, so two sync stages leave the output in phase with it
        chk("receive", 24'(rx), 24'(rxo));
        chk("ring", 24'h1, ring);
        chk("carrier", 24'h1, dcd);
        chk("transmit", 24'h0, channel_transmit_line);
        chk("sync clock", 24'h1, h > 0);
        wait_hi(1'b1, 40);
        @(posedge clk);
        #1;
        wait_hi(1'b1, 40);
        chk("tick gap", 24'd19, 24'(k));
        @(posedge clk);
        seize <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("on hook", 24'h1, hook_n);
        end_sim();
    end
endmodule
`default_nettype wire
